/* File: hdl/fpc_top.sv */
// Flash command sequencer with an APB register port, driving a parallel flash.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"
module fpc_top
   import fpc_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = `FPC_WINDOW_US * `FPC_CLK_MHZ
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [22:0] o_flash_addr,
   output logic [15:0] o_flash_dq,
   output logic o_flash_dq_oe_n,
   input wire logic [15:0] i_flash_dq,
   output logic o_flash_ce_n,
   output logic o_flash_we_n,
   output logic o_flash_oe_n,
   output logic o_flash_reset_n,
   output logic o_flash_byte_n,
   output logic o_protect_accelerate_pin,
   input wire logic i_ready_busy_output
);
   typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAITC, S_SETTLE, S_BUSY, S_VERIFY, S_VWAIT, S_HWRST} fpc_st_t;

   fpc_cyc_if cyc();

   fpc_st_t state, next_state;
   fpc_op_t op, next_op;
   fpc_addr_t addr, next_addr;
   fpc_data_t wdata, next_wdata, rdata, next_rdata;
   logic [2:0] idx, next_idx, last, next_last;
   logic [7:0] cnt, next_cnt;
   logic [13:0] win, next_win;
   logic byte_mode, next_byte_mode, acc_req, next_acc_req;
   logic secure, next_secure, bypass, next_bypass, sect_act, next_sect_act;
   logic refused, next_refused, verr, next_verr, req, next_req, rd, next_rd;
   logic wr, wr_cmd, win_open, acc_on, byp_eff, rdy, ok;
   logic [9:0] step;
   logic [7:0] st_word;

   // Step table: {address kind, command byte} of cycle i of each full sequence.
   function automatic logic [9:0] seq_step(input fpc_op_t o, input logic [2:0] i);
      logic [7:0] c;
      c = `FPC_CODE_RESET;
      case (o)
         `FPC_OP_PROGRAM: c = `FPC_CODE_PROGRAM;
         `FPC_OP_SEC_ENTER: c = `FPC_CODE_SEC_ENTER;
         `FPC_OP_SEC_EXIT: c = `FPC_CODE_SEC_EXIT;
         `FPC_OP_BYP_ENTER: c = `FPC_CODE_BYPASS;
         `FPC_OP_CHIP_ERASE, `FPC_OP_SECT_ERASE: c = `FPC_CODE_ERASE_SETUP;
         default: c = `FPC_CODE_RESET;
      endcase
      case (i)
         3'h0, 3'h3: seq_step = {`FPC_K_U1, `FPC_CODE_UNLOCK1};
         3'h1, 3'h4: seq_step = {`FPC_K_U2, `FPC_CODE_UNLOCK2};
         3'h2: seq_step = {`FPC_K_U1, c};
         default: seq_step = {`FPC_K_USR, (o == `FPC_OP_CHIP_ERASE) ? `FPC_CODE_CHIP : `FPC_CODE_SECTOR};
      endcase
      // Program's fourth cycle and the exit's fourth cycle differ from the erase tail.
      if (i == 3'h3 && o == `FPC_OP_PROGRAM)
         seq_step = {`FPC_K_DATA, 8'h00};
      if (i == 3'h3 && o == `FPC_OP_SEC_EXIT)
         seq_step = {`FPC_K_USR, `FPC_CODE_EXIT2};
   endfunction

   fpc_bus_cycle u_eng (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .cyc(cyc.eng),
      .o_flash_addr(o_flash_addr),
      .o_flash_dq(o_flash_dq),
      .o_flash_dq_oe_n(o_flash_dq_oe_n),
      .i_flash_dq(i_flash_dq),
      .o_flash_ce_n(o_flash_ce_n),
      .o_flash_we_n(o_flash_we_n),
      .o_flash_oe_n(o_flash_oe_n)
   );

   // Mode summary and the admission check for a new command.
   always_comb
   begin
      rdy = i_ready_busy_output;
      win_open = (win != 14'h0000);
      acc_on = acc_req && !secure;
      byp_eff = bypass || acc_on;
      wr = i_psel && i_penable && i_pwrite;
      wr_cmd = wr && (i_paddr == `FPC_REG_CMD);
      case (i_pwdata[3:0])
         `FPC_OP_READ: ok = 1'b1;
         `FPC_OP_PROGRAM: ok = rdy && !win_open;
         `FPC_OP_SEC_ENTER: ok = rdy && !win_open && !byp_eff;
         `FPC_OP_SEC_EXIT: ok = rdy && secure && !byp_eff;
         `FPC_OP_BYP_ENTER: ok = rdy && !win_open && !secure && !bypass;
         `FPC_OP_BYP_RESET: ok = rdy && bypass && !acc_on;
         `FPC_OP_CHIP_ERASE: ok = rdy && !win_open && !byp_eff;
         `FPC_OP_SECT_ERASE: ok = win_open || (rdy && !byp_eff);
         `FPC_OP_RESET: ok = rdy && !win_open && !byp_eff;
         `FPC_OP_SUSPEND: ok = sect_act;
         `FPC_OP_HW_RESET: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      step = seq_step(op, idx);
   end

   // Sequencer, mode flags, window timer and software-visible registers.
   always_comb
   begin
      next_state = state;
      next_op = op;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_idx = idx;
      next_last = last;
      next_cnt = cnt;
      next_win = win_open ? win - 14'h0001 : win;
      next_byte_mode = byte_mode;
      next_acc_req = acc_req;
      next_secure = secure;
      next_bypass = bypass;
      next_sect_act = (sect_act && !(rdy && !win_open && state == S_IDLE));
      next_refused = refused;
      next_verr = verr;
      next_req = 1'b0;
      next_rd = rd;
      // Sticky flags clear on a written one; a same-cycle set below still wins.
      if (wr && i_paddr == `FPC_REG_STATUS)
      begin
         next_refused = refused && !i_pwdata[`FPC_ST_REFUSED];
         next_verr = verr && !i_pwdata[`FPC_ST_VERR];
      end
      if (wr && i_paddr == `FPC_REG_ADDR)
         next_addr = i_pwdata[22:0];
      if (wr && i_paddr == `FPC_REG_WDATA)
         next_wdata = i_pwdata[15:0];
      if (wr && i_paddr == `FPC_REG_CFG)
      begin
         next_byte_mode = i_pwdata[0];
         next_acc_req = i_pwdata[1];
      end
      // A command written mid-sequence is dropped and flagged, never queued behind the running one.
      if (wr_cmd && state != S_IDLE)
         next_refused = 1'b1;
      case (state)
         S_IDLE:
            if (wr_cmd)
            begin
               if (!ok)
                  next_refused = 1'b1;
               else
               begin
                  next_op = i_pwdata[3:0];
                  next_rd = (i_pwdata[3:0] == `FPC_OP_READ);
                  next_state = S_ISSUE;
                  case (i_pwdata[3:0])
                     `FPC_OP_PROGRAM: next_idx = byp_eff ? 3'h2 : 3'h0;
                     `FPC_OP_SEC_EXIT: next_idx = 3'h0;
                     `FPC_OP_SECT_ERASE: next_idx = win_open ? 3'h5 : 3'h0;
                     `FPC_OP_CHIP_ERASE: next_idx = 3'h0;
                     `FPC_OP_BYP_RESET: next_idx = 3'h6;
                     `FPC_OP_HW_RESET: next_idx = 3'h0;
                     `FPC_OP_SEC_ENTER, `FPC_OP_BYP_ENTER: next_idx = 3'h0;
                     default: next_idx = 3'h7;
                  endcase
                  case (i_pwdata[3:0])
                     `FPC_OP_PROGRAM, `FPC_OP_SEC_EXIT: next_last = 3'h3;
                     `FPC_OP_SEC_ENTER, `FPC_OP_BYP_ENTER: next_last = 3'h2;
                     `FPC_OP_CHIP_ERASE, `FPC_OP_SECT_ERASE: next_last = 3'h5;
                     default: next_last = 3'h7;
                  endcase
                  if (i_pwdata[3:0] == `FPC_OP_HW_RESET)
                  begin
                     next_cnt = `FPC_HWRST_CYC;
                     next_state = S_HWRST;
                  end
               end
            end
         S_ISSUE:
         begin
            next_req = 1'b1;
            next_state = S_WAITC;
         end
         S_WAITC:
            if (cyc.done)
            begin
               if (rd)
                  next_rdata = cyc.rdata;
               if (idx != last)
               begin
                  next_idx = idx + 3'h1;
                  next_state = S_ISSUE;
               end
               else
               begin
                  next_state = S_IDLE;
                  case (op)
                     `FPC_OP_PROGRAM, `FPC_OP_CHIP_ERASE:
                     begin
                        next_cnt = `FPC_SETTLE_CYC;
                        next_state = S_SETTLE;
                     end
                     `FPC_OP_SEC_ENTER: next_secure = 1'b1;
                     `FPC_OP_SEC_EXIT: next_secure = 1'b0;
                     `FPC_OP_BYP_ENTER: next_bypass = 1'b1;
                     `FPC_OP_SECT_ERASE:
                     begin
                        next_win = WINDOW_CYC[13:0];
                        next_sect_act = 1'b1;
                     end
                     `FPC_OP_SUSPEND, `FPC_OP_RESET: next_win = 14'h0000;
                     default: next_state = S_IDLE;
                  endcase
                  if (op == `FPC_OP_BYP_RESET && idx == 3'h7)
                     next_bypass = 1'b0;
               end
            end
         S_SETTLE:
            if (cnt == 8'h01)
               next_state = S_BUSY;
            else
               next_cnt = cnt - 8'h01;
         S_BUSY:
            if (rdy)
               next_state = (op == `FPC_OP_PROGRAM) ? S_VERIFY : S_IDLE;
         S_VERIFY:
         begin
            next_req = 1'b1;
            next_rd = 1'b1;
            next_state = S_VWAIT;
         end
         S_VWAIT:
            if (cyc.done)
            begin
               next_rdata = cyc.rdata;
               // A bit left at 0 where 1 was asked cannot be repaired without an erase.
               if (byte_mode ? (cyc.rdata[7:0] != wdata[7:0]) : (cyc.rdata != wdata))
                  next_verr = 1'b1;
               next_state = S_IDLE;
            end
         S_HWRST:
         begin
            next_secure = 1'b0;
            next_bypass = 1'b0;
            next_sect_act = 1'b0;
            next_win = 14'h0000;
            if (cnt == 8'h01)
               next_state = S_IDLE;
            else
               next_cnt = cnt - 8'h01;
         end
         default: next_state = S_IDLE;
      endcase
   end

   // Request fields for the pin engine follow the step table.
   always_comb
   begin
      cyc.req = req;
      cyc.is_read = rd;
      cyc.wdata = {8'h00, step[7:0]};
      case (step[9:8])
         `FPC_K_U1: cyc.addr = byte_mode ? `FPC_ADDR_U1_BYTE : `FPC_ADDR_U1_WORD;
         `FPC_K_U2: cyc.addr = byte_mode ? `FPC_ADDR_U2_BYTE : `FPC_ADDR_U2_WORD;
         default: cyc.addr = addr;
      endcase
      if (step[9:8] == `FPC_K_DATA || rd)
         cyc.wdata = wdata;
      if (idx == 3'h7)
         case (op)
            `FPC_OP_SUSPEND: cyc.wdata = {8'h00, `FPC_CODE_SUSPEND};
            `FPC_OP_RESET: cyc.wdata = {8'h00, `FPC_CODE_RESET};
            default: cyc.wdata = {8'h00, `FPC_CODE_EXIT2};
         endcase
      if (op == `FPC_OP_BYP_RESET && idx == 3'h6)
         cyc.wdata = {8'h00, `FPC_CODE_SEC_EXIT};
      st_word = {acc_on, rdy, win_open, byp_eff, secure, verr, refused, state != S_IDLE};
      case (i_paddr)
         `FPC_REG_CMD: o_prdata = {28'h0000000, op};
         `FPC_REG_ADDR: o_prdata = {9'h000, addr};
         `FPC_REG_WDATA: o_prdata = {16'h0000, wdata};
         `FPC_REG_CFG: o_prdata = {30'h00000000, acc_req, byte_mode};
         `FPC_REG_STATUS: o_prdata = {24'h000000, st_word};
         `FPC_REG_RDATA: o_prdata = {16'h0000, rdata};
         default: o_prdata = 32'h00000000;
      endcase
      o_pready = 1'b1;
      o_pslverr = i_psel && i_penable && (i_paddr > `FPC_REG_RDATA || i_paddr[1:0] != 2'h0);
   end

   // Idle bypass reset runs its two cycles from idx 6 to 7.
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= S_IDLE;
         op <= `FPC_OP_READ;
         addr <= 23'h000000;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         idx <= 3'h0;
         last <= 3'h0;
         cnt <= 8'h00;
         win <= 14'h0000;
         byte_mode <= 1'b0;
         acc_req <= 1'b0;
         secure <= 1'b0;
         bypass <= 1'b0;
         sect_act <= 1'b0;
         refused <= 1'b0;
         verr <= 1'b0;
         req <= 1'b0;
         rd <= 1'b0;
         o_flash_reset_n <= 1'b0;
         o_flash_byte_n <= 1'b1;
         o_protect_accelerate_pin <= 1'b0;
      end
      else
      begin
         state <= next_state;
         op <= next_op;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         idx <= next_idx;
         last <= (next_op == `FPC_OP_BYP_RESET || next_idx == 3'h7) ? 3'h7 : next_last;
         cnt <= next_cnt;
         win <= next_win;
         byte_mode <= next_byte_mode;
         acc_req <= next_acc_req;
         secure <= next_secure;
         bypass <= next_bypass;
         sect_act <= next_sect_act;
         refused <= next_refused;
         verr <= next_verr;
         req <= next_req;
         rd <= next_rd;
         o_flash_reset_n <= (next_state != S_HWRST);
         o_flash_byte_n <= !next_byte_mode;
         o_protect_accelerate_pin <= next_acc_req && !next_secure;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/fpc_defines.svh */
// Constants for the flash program and erase command controller.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// Register byte offsets on the APB side.
`define FPC_REG_CMD 8'h00
`define FPC_REG_ADDR 8'h04
`define FPC_REG_WDATA 8'h08
`define FPC_REG_CFG 8'h0c
`define FPC_REG_STATUS 8'h10
`define FPC_REG_RDATA 8'h14
// Operation codes written to the command register.
`define FPC_OP_READ 4'h0
`define FPC_OP_PROGRAM 4'h1
`define FPC_OP_SEC_ENTER 4'h2
`define FPC_OP_SEC_EXIT 4'h3
`define FPC_OP_BYP_ENTER 4'h4
`define FPC_OP_BYP_RESET 4'h5
`define FPC_OP_CHIP_ERASE 4'h6
`define FPC_OP_SECT_ERASE 4'h7
`define FPC_OP_RESET 4'h8
`define FPC_OP_SUSPEND 4'h9
`define FPC_OP_HW_RESET 4'ha
// Flash command codes and unlock addresses, word mode then byte mode.
`define FPC_CODE_UNLOCK1 8'haa
`define FPC_CODE_UNLOCK2 8'h55
`define FPC_CODE_PROGRAM 8'ha0
`define FPC_CODE_SEC_ENTER 8'h88
`define FPC_CODE_SEC_EXIT 8'h90
`define FPC_CODE_EXIT2 8'h00
`define FPC_CODE_BYPASS 8'h20
`define FPC_CODE_ERASE_SETUP 8'h80
`define FPC_CODE_CHIP 8'h10
`define FPC_CODE_SECTOR 8'h30
`define FPC_CODE_RESET 8'hf0
`define FPC_CODE_SUSPEND 8'hb0
`define FPC_ADDR_U1_WORD 23'h000555
`define FPC_ADDR_U2_WORD 23'h0002aa
`define FPC_ADDR_U1_BYTE 23'h000aaa
`define FPC_ADDR_U2_BYTE 23'h000555
// Sequence step kinds: address source in bits 9:8.
`define FPC_K_U1 2'h0
`define FPC_K_U2 2'h1
`define FPC_K_USR 2'h2
`define FPC_K_DATA 2'h3
// Status bit positions.
`define FPC_ST_BUSY 0
`define FPC_ST_REFUSED 1
`define FPC_ST_VERR 2
`define FPC_ST_SECURE 3
`define FPC_ST_BYPASS 4
`define FPC_ST_WINDOW 5
`define FPC_ST_READY 6
`define FPC_ST_ACC 7
// Timing at 125 MHz: the window in microseconds, the other delays in clock cycles.
`define FPC_CLK_MHZ 125
`define FPC_WINDOW_US 80
`define FPC_SETUP_CYC 4'h1
`define FPC_WE_CYC 4'h5
`define FPC_HOLD_CYC 4'h2
`define FPC_RD_CYC 4'hc
`define FPC_SETTLE_CYC 8'h20
`define FPC_HWRST_CYC 8'h40
`endif

/* File: hdl/fpc_pkg.sv */
// Types shared by the flash command controller modules.
package fpc_pkg;
   typedef logic [3:0] fpc_op_t;
   typedef logic [22:0] fpc_addr_t;
   typedef logic [15:0] fpc_data_t;
endpackage

/* File: hdl/fpc_cyc_if.sv */
// Request and answer of one flash bus cycle between sequencer and pin engine.
`timescale 1ns/1ps
`default_nettype none
interface fpc_cyc_if;
   import fpc_pkg::*;
   logic req;
   logic is_read;
   fpc_addr_t addr;
   fpc_data_t wdata;
   logic done;
   fpc_data_t rdata;
   modport seq (output req, output is_read, output addr, output wdata, input done, input rdata);
   modport eng (input req, input is_read, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

/* File: hdl/fpc_bus_cycle.sv */
// Pin engine: runs one asynchronous write or read cycle on the flash pins.
`timescale 1ns/1ps
`default_nettype none
module fpc_bus_cycle
   import fpc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   fpc_cyc_if.eng cyc,
   output logic [22:0] o_flash_addr,
   output logic [15:0] o_flash_dq,
   output logic o_flash_dq_oe_n,
   input wire logic [15:0] i_flash_dq,
   output logic o_flash_ce_n,
   output logic o_flash_we_n,
   output logic o_flash_oe_n
);
   typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_READ} fpc_eng_t;
   fpc_eng_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic rd, next_rd, next_done;
   fpc_addr_t next_addr;
   fpc_data_t next_dq, next_rdata;
   logic next_ce_n, next_we_n, next_oe_n, next_dq_oe_n;

   // Chip enable falls first, write strobe later, so the address is taken on the later fall and
   // data on the write strobe rise while chip enable is still low.
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_rd = rd;
      next_done = 1'b0;
      next_addr = o_flash_addr;
      next_dq = o_flash_dq;
      next_rdata = cyc.rdata;
      case (state)
         E_IDLE:
            if (cyc.req)
            begin
               next_addr = cyc.addr;
               next_dq = cyc.wdata;
               next_rd = cyc.is_read;
               next_cnt = `FPC_SETUP_CYC;
               next_state = E_SETUP;
            end
         E_SETUP:
            if (cnt == 4'h1)
            begin
               next_cnt = rd ? `FPC_RD_CYC : `FPC_WE_CYC;
               next_state = rd ? E_READ : E_STROBE;
            end
            else
               next_cnt = cnt - 4'h1;
         E_STROBE:
            if (cnt == 4'h1)
            begin
               next_cnt = `FPC_HOLD_CYC;
               next_state = E_HOLD;
            end
            else
               next_cnt = cnt - 4'h1;
         E_HOLD:
            if (cnt == 4'h1)
            begin
               next_done = 1'b1;
               next_state = E_IDLE;
            end
            else
               next_cnt = cnt - 4'h1;
         E_READ:
            if (cnt == 4'h1)
            begin
               next_rdata = i_flash_dq;
               next_done = 1'b1;
               next_state = E_IDLE;
            end
            else
               next_cnt = cnt - 4'h1;
         default:
            next_state = E_IDLE;
      endcase
      // Chip enable stays low through the hold, so the write strobe rise is always the earlier one.
      next_ce_n = !(next_state == E_SETUP || next_state == E_STROBE || next_state == E_HOLD ||
         next_state == E_READ);
      next_we_n = (next_state != E_STROBE);
      next_oe_n = (next_state != E_READ);
      // Data stays driven through the hold so it never changes before the strobe rises.
      next_dq_oe_n = !(!next_rd && next_state != E_IDLE && next_state != E_READ);
   end

   // Pins are registered so the strobes never glitch.
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= E_IDLE;
         cnt <= 4'h0;
         rd <= 1'b0;
         cyc.done <= 1'b0;
         cyc.rdata <= 16'h0000;
         o_flash_addr <= 23'h000000;
         o_flash_dq <= 16'h0000;
         o_flash_dq_oe_n <= 1'b1;
         o_flash_ce_n <= 1'b1;
         o_flash_we_n <= 1'b1;
         o_flash_oe_n <= 1'b1;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         rd <= next_rd;
         cyc.done <= next_done;
         cyc.rdata <= next_rdata;
         o_flash_addr <= next_addr;
         o_flash_dq <= next_dq;
         o_flash_dq_oe_n <= next_dq_oe_n;
         o_flash_ce_n <= next_ce_n;
         o_flash_we_n <= next_we_n;
         o_flash_oe_n <= next_oe_n;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/fpc_top_monitor.sv */
// Port checker for the flash command controller.
`timescale 1ns/1ps
`default_nettype none
module fpc_top_monitor (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [7:0] i_paddr,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_flash_dq_oe_n,
   input wire logic o_flash_ce_n,
   input wire logic o_flash_we_n,
   input wire logic o_flash_oe_n,
   input wire logic [22:0] o_flash_addr,
   input wire logic [15:0] o_flash_dq
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // Strobe shape on the flash pins and the APB error answer.
   a_we_in_ce: assert property (!o_flash_we_n |-> !o_flash_ce_n)
      else $error("we outside ce");
   a_we_drives_dq: assert property (!o_flash_we_n |-> !o_flash_dq_oe_n)
      else $error("dq undriven");
   a_strobes_apart: assert property (o_flash_we_n || o_flash_oe_n)
      else $error("we and oe both low");
   a_read_released: assert property (!o_flash_oe_n |-> o_flash_dq_oe_n)
      else $error("dq driven in read");
   a_we_width: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*4])
      else $error("we too short");
   a_addr_held: assert property (!o_flash_we_n ##1 !o_flash_we_n |->
      $stable(o_flash_addr) && $stable(o_flash_dq)) else $error("addr moved");
   a_data_hold: assert property ($rose(o_flash_we_n) |-> !o_flash_ce_n && !o_flash_dq_oe_n)
      else $error("data dropped");
   a_unmapped_err: assert property (i_psel && i_penable && i_paddr > 8'h14 |-> o_pslverr && o_pready)
      else $error("no slave error");
endmodule
bind fpc_top fpc_top_monitor fpc_top_monitor_i (.*);
`default_nettype wire

/* File: testbench/fpc_flash_model.sv */
// Behavioural flash device answering the controller's pin cycles.
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
   input wire logic i_clk, i_rst_n, i_ce_n, i_we_n, i_oe_n, i_acc,
   input wire logic [22:0] i_a,
   input wire logic [15:0] i_d,
   output logic [15:0] o_q,
   output logic o_rb
);
   logic [15:0] mem [int];
   logic [22:0] la;
   logic [3:0] st;
   logic sec, byp, we_q;
   int busy;
   wire [7:0] d = i_d[7:0];
   wire bp = byp | (i_acc & !sec);
   assign o_rb = busy == 0;
   // Strobe edges are seen on the clock; an idle bus shows a changing pattern.
   always @(posedge i_clk)
   begin
      we_q <= i_we_n;
      busy <= busy > 0 ? busy - 1 : 0;
      o_q <= ~o_q;
      if (!i_ce_n && !i_oe_n)
         o_q <= busy > 0 ? {9'h0, busy[0], 6'h0} : sec ? {12'h5e5, i_a[3:0]} :
            mem.exists(i_a) ? mem[i_a] : 16'hffff;
      if (!i_we_n && we_q)
         la <= i_a;
      if (!i_rst_n)
      begin
         st <= 0; sec <= 0; byp <= 0; busy <= 0; o_q <= 0;
      end
      else if (i_we_n && !we_q && busy == 0)
      begin
         st <= 0;
         if (d != 8'hf0 || st == 3)
            case (st)
               0: st <= bp ? (d == 8'ha0 ? 3 : d == 8'h90 ? 5 : 0) : (d == 8'haa ? 1 : 0);
               1: st <= d == 8'h55 ? 2 : 0;
               2: st <= d == 8'ha0 ? 3 : d == 8'h90 ? 4 : d == 8'h80 ? 6 : 0;
               3: mem[la] = mem.exists(la) ? mem[la] & i_d : i_d;
               4: sec <= 0;
               5: byp <= 0;
               6: st <= d == 8'haa ? 7 : 0;
               7: st <= d == 8'h55 ? 8 : 0;
               8: if (d == 8'h10) mem.delete();
               default: ;
            endcase
         if (st == 2 && d == 8'h88) sec <= 1;
         if (st == 2 && d == 8'h20 && !sec) byp <= 1;
         if (st == 3 || (st == 8 && (d == 8'h10 || d == 8'h30))) busy <= 40;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the flash command controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clk = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic [7:0] i_paddr = 8'h0;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rv, d, a, seed = 32'h4517f60d;
   logic o_pready, o_pslverr, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, o_flash_reset_n, acc, rb;
   logic [22:0] o_flash_addr;
   logic [15:0] o_flash_dq, fq;
   logic [63:0] q[$], nt;
   int failures = 0, samples_checked = 0;
   fpc_top #(.WINDOW_CYC(200)) fpc_top_i (.*, .i_flash_dq(fq), .o_flash_dq_oe_n(), .o_flash_byte_n(),
      .o_protect_accelerate_pin(acc), .i_ready_busy_output(rb));
   fpc_flash_model fpc_flash_model_i (.i_clk(i_clk), .i_rst_n(o_flash_reset_n), .i_ce_n(o_flash_ce_n),
      .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n), .i_acc(acc), .i_a(o_flash_addr), .i_d(o_flash_dq),
      .o_q(fq), .o_rb(rb));
   initial forever #4 i_clk = ~i_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic end_sim();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // The watcher takes the oldest note at each completed read; mask zero means poll only.
   always @(posedge i_clk)
      if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite && q.size() > 0)
      begin
         nt = q.pop_front();
         if (nt[63:32] != 0)
            cmp(nt[31:0], o_prdata & nt[63:32]);
      end
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      i_psel <= 1'b1; i_pwrite <= w; i_paddr <= ad; i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1 && ++n < 50);
      rv = o_prdata;
      i_psel <= 1'b0; i_penable <= 1'b0;
      if (n == 50)
      begin
         failures++; end_sim();
      end
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
      q.push_back({m, e & m});
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic op(input logic [3:0] o);
      int n;
      apb(1'b1, 8'h00, {28'h0, o});
      for (n = 0, rv = 32'h1; rv[0] !== 1'b0; n++)
      begin
         if (n == 999)
         begin
            failures++; end_sim();
         end
         rd(8'h10, 32'h0, 32'h0);
      end
   endtask
   task automatic prog(input logic [31:0] ad, input logic [31:0] dt);
      apb(1'b1, 8'h04, ad); apb(1'b1, 8'h08, dt); op(4'h1); op(4'h0);
   endtask
   // Main sequence: program, secure, accelerate, bypass, erase.
   initial
   begin
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      a = rnd() & 32'h7fff0;
      d = rnd() & 32'hfeff;
      prog(a, d);
      rd(8'h14, d, 32'hffff);
      rd(8'h10, 32'h0, 32'h4);
      prog(a, 32'hffff);
      rd(8'h14, d, 32'hffff);
      rd(8'h10, 32'h4, 32'h4);
      apb(1'b1, 8'h10, 32'h4);
      $display("program test done");
      op(4'h2); apb(1'b1, 8'h04, 32'h3); op(4'h0);
      rd(8'h14, 32'h5e53, 32'hffff);
      op(4'h4); apb(1'b1, 8'h0c, 32'h2);
      rd(8'h10, 32'ha, 32'h9a);
      apb(1'b1, 8'h10, 32'h2); apb(1'b1, 8'h04, a); op(4'h3); op(4'h0);
      rd(8'h14, d, 32'hffff);
      rd(8'h10, 32'h90, 32'h98);
      d = rnd() & 32'hffff;
      prog(a + 32'h10, d);
      rd(8'h14, d, 32'hffff);
      apb(1'b1, 8'h0c, 32'h0); op(4'h4);
      rd(8'h10, 32'h10, 32'h10);
      prog(a + 32'h20, ~d);
      rd(8'h14, ~d, 32'hffff);
      op(4'h2);
      rd(8'h10, 32'h2, 32'ha);
      apb(1'b1, 8'h10, 32'h2); op(4'h5);
      rd(8'h10, 32'h0, 32'h10);
      $display("secure and bypass test done");
      op(4'h6); apb(1'b1, 8'h04, a); op(4'h0);
      rd(8'h14, 32'hffff, 32'hffff);
      op(4'h7);
      rd(8'h10, 32'h20, 32'h20);
      op(4'h0);
      rd(8'h10, 32'h20, 32'h23);
      apb(1'b1, 8'h00, 32'h1);
      rd(8'h10, 32'h2, 32'h2);
      op(4'h7); op(4'h9);
      rd(8'h10, 32'h0, 32'h20);
      op(4'h8); op(4'ha);
      rd(8'h10, 32'h40, 32'h61);
      rd(8'h18, 32'h0, 32'hffffffff);
      $display("erase test done");
      end_sim();
   end
endmodule
`default_nettype wire
